// *** hw/asr_receiver.sv ***
// Asynchronous serial receive path with transmit set-up flags
// What this block does
// - Sample line at sixteen times baud rate
// - Run only when enabled, asynchronous, port on
// - Recheck start at half bit, else abandon
// - Majority-sample each data bit one bit later
// - Low stop sample marks framing error
// - Push character, raise pending after stop
// - Two-character buffer, read pops oldest
// - Pending high while enabled and unread
// - Interrupt needs pending and three enables
// - Framing status per entry, oldest shown
// - Framing cleared by read or port disable
// - Third character sets overrun, reception stops
// - Overrun cleared by receive or port disable
// - Nine-bit mode stores ninth bit per entry
// - Filtering in nine-bit mode keeps only ninth-bit-set characters
// - Ninth bit one marks an address
// - Transmit enable sets empty flag, interrupt
// - Transmit data write starts transmission
// - LSB first, low start, high stop
`timescale 1ns/1ps
module asr_receiver (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	input wire logic serial_input_pin_i,
	input wire logic os_tick_i,
	input wire logic port_enable_i,
	input wire logic receive_enable_i,
	input wire logic sync_select_i,
	input wire logic nine_bit_receive_i,
	input wire logic address_filter_enable_i,
	input wire logic receive_irq_enable_i,
	input wire logic peripheral_irq_enable_i,
	input wire logic global_irq_enable_i,
	input wire logic receive_data_read_i,
	input wire logic transmit_enable_i,
	input wire logic transmit_irq_enable_i,
	input wire logic nine_bit_transmit_i,
	input wire logic transmit_ninth_bit_i,
	input wire logic [7:0] transmit_data_register_i,
	input wire logic transmit_write_i,
	input wire logic transmit_taken_i,
	output logic [7:0] receive_data_register_o,
	output logic receive_ninth_bit_o,
	output logic framing_error_flag_o,
	output logic overrun_flag_o,
	output logic receive_pending_flag_o,
	output logic receive_irq_o,
	output logic transmit_empty_flag_o,
	output logic transmit_irq_o,
	output logic transmit_start_o,
	output logic [8:0] transmit_char_o,
	output logic receive_idle_o
);
	asr_fifo_if fif ();
	asr_fifo u_fifo (
		.clk_sys_i(clk_sys_i),
		.srst_i(srst_i),
		.f(fif)
	);

	// Line synchroniser
	logic rx_meta_r;
	logic rx_sync_r;
	logic rx_prev_r;
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			rx_meta_r <= 1'b1;
			rx_sync_r <= 1'b1;
		end else begin
			rx_meta_r <= serial_input_pin_i;
			rx_sync_r <= rx_meta_r;
		end
	end

	// Enables
	wire rx_on = receive_enable_i && !sync_select_i && port_enable_i;
	wire tx_on = transmit_enable_i && !sync_select_i && port_enable_i;

	asr_pkg::asr_state_e state_r;
	asr_pkg::asr_state_e state_nxt;
	logic [3:0] os_cnt_r;
	logic [3:0] bit_cnt_r;
	logic [8:0] shift_r;
	logic [2:0] vote_r;
	logic overrun_r;
	logic push_r;
	logic [9:0] push_data_r;

	wire fall = rx_prev_r && !rx_sync_r;
	wire [3:0] nbits = nine_bit_receive_i ? asr_pkg::DATA_BITS_9 : asr_pkg::DATA_BITS_8;
	wire vote_maj = (vote_r[0] & vote_r[1]) | (vote_r[1] & vote_r[2]) | (vote_r[0] & vote_r[2]);
	wire at_half = os_tick_i && os_cnt_r == asr_pkg::OS_HALF;
	wire at_centre = os_tick_i && os_cnt_r == asr_pkg::OS_CENTRE;
	wire vote_win = os_tick_i && (os_cnt_r == 4'hC || os_cnt_r == 4'hD || os_cnt_r == 4'hE);
	wire last_data = bit_cnt_r == 4'(nbits - 4'h1);
	wire stop_done = state_r == asr_pkg::ASR_STOP && at_centre;
	wire [8:0] char_word = nine_bit_receive_i ? shift_r : {1'b0, shift_r[8:1]};
	wire keep_char = !(address_filter_enable_i && nine_bit_receive_i) || char_word[8];

	// Receive sequencer
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			asr_pkg::ASR_IDLE: if (fall && !overrun_r) state_nxt = asr_pkg::ASR_START;
			asr_pkg::ASR_START: if (at_half) state_nxt = rx_sync_r ? asr_pkg::ASR_IDLE : asr_pkg::ASR_DATA;
			asr_pkg::ASR_DATA: if (at_centre && last_data) state_nxt = asr_pkg::ASR_STOP;
			asr_pkg::ASR_STOP: if (at_centre) state_nxt = asr_pkg::ASR_IDLE;
			default: state_nxt = asr_pkg::ASR_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (srst_i || !rx_on) begin
			state_r <= asr_pkg::ASR_IDLE;
			os_cnt_r <= 4'h0;
			bit_cnt_r <= 4'h0;
			rx_prev_r <= 1'b1;
			vote_r <= 3'h7;
			shift_r <= asr_pkg::CHAR_RESET;
		end else begin
			state_r <= state_nxt;
			rx_prev_r <= rx_sync_r;
			if (state_r == asr_pkg::ASR_IDLE || (state_r == asr_pkg::ASR_START && at_half))
				os_cnt_r <= 4'h0;
			else if (os_tick_i)
				os_cnt_r <= 4'(os_cnt_r + 4'h1);
			if (vote_win)
				vote_r <= {vote_r[1:0], rx_sync_r};
			if (state_r == asr_pkg::ASR_START)
				bit_cnt_r <= 4'h0;
			else if (state_r == asr_pkg::ASR_DATA && at_centre) begin
				shift_r <= {vote_maj, shift_r[8:1]};
				bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
			end
		end
	end

	// Hand-off to the buffer and overrun
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || !port_enable_i || !receive_enable_i) begin
			overrun_r <= 1'b0;
			push_r <= 1'b0;
			push_data_r <= 10'h000;
		end else begin
			if (push_r && fif.in_ready)
				push_r <= 1'b0;
			if (stop_done && keep_char && !overrun_r) begin
				if (fif.in_ready) begin
					push_r <= 1'b1;
					push_data_r <= {!vote_maj, char_word};
				end else
					overrun_r <= 1'b1;
			end
		end
	end

	assign fif.in_valid = push_r && rx_on;
	assign fif.in_data = push_data_r;
	assign fif.flush = !port_enable_i;
	assign fif.out_ready = receive_data_read_i;

	// Oldest entry shown
	always_ff @(posedge clk_sys_i) begin
		if (srst_i) begin
			receive_data_register_o <= 8'h00;
			receive_ninth_bit_o <= 1'b0;
			framing_error_flag_o <= 1'b0;
		end else if (!port_enable_i) begin
			framing_error_flag_o <= 1'b0;
			receive_ninth_bit_o <= 1'b0;
		end else begin
			receive_data_register_o <= fif.out_data[7:0];
			receive_ninth_bit_o <= fif.out_valid && fif.out_data[8];
			framing_error_flag_o <= fif.out_valid && fif.out_data[9];
		end
	end

	assign overrun_flag_o = overrun_r;
	assign receive_pending_flag_o = rx_on && fif.out_valid;
	assign receive_irq_o = receive_pending_flag_o && receive_irq_enable_i && peripheral_irq_enable_i
		&& global_irq_enable_i;
	assign receive_idle_o = state_r == asr_pkg::ASR_IDLE;

	// Transmit holding register and empty flag
	logic tx_full_r;
	logic [8:0] tx_hold_r;
	always_ff @(posedge clk_sys_i) begin
		if (srst_i || !tx_on) begin
			tx_full_r <= 1'b0;
			tx_hold_r <= asr_pkg::CHAR_RESET;
		end else if (transmit_write_i) begin
			tx_full_r <= 1'b1;
			tx_hold_r <= {nine_bit_transmit_i && transmit_ninth_bit_i, transmit_data_register_i};
		end else if (transmit_taken_i)
			tx_full_r <= 1'b0;
	end
	assign transmit_empty_flag_o = tx_on && !tx_full_r;
	assign transmit_irq_o = transmit_empty_flag_o && transmit_irq_enable_i && peripheral_irq_enable_i
		&& global_irq_enable_i;
	assign transmit_start_o = tx_full_r;
	assign transmit_char_o = tx_hold_r;

	// Checks
	sequence start_abort_s;
		state_r == asr_pkg::ASR_START && at_half && rx_sync_r;
	endsequence
	start_abort_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		start_abort_s |=> state_r == asr_pkg::ASR_IDLE && !push_r)
		else $error("start not abandoned");
	rx_gate_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!rx_on |=> state_r == asr_pkg::ASR_IDLE)
		else $error("receiver ran while disabled");
	pend_flag_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		receive_pending_flag_o == (rx_on && fif.out_valid))
		else $error("pending flag wrong");
	rx_irq_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		receive_irq_o |-> receive_pending_flag_o && global_irq_enable_i)
		else $error("interrupt without cause");
	ovr_clear_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!receive_enable_i |=> !overrun_flag_o)
		else $error("overrun not cleared");
	ovr_block_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		overrun_r && rx_on |=> state_r != asr_pkg::ASR_START || $past(state_r) != asr_pkg::ASR_IDLE)
		else $error("reception after overrun");
	framing_error_flag_clear_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		!port_enable_i |=> !framing_error_flag_o)
		else $error("framing flag kept");
	stop_push_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		stop_done && keep_char && !overrun_r && fif.in_ready && rx_on |=> push_r)
		else $error("character not pushed");
	sequence full_stop_s;
		stop_done && keep_char && !overrun_r && rx_on && !fif.in_ready;
	endsequence
	ovr_set_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		full_stop_s |=> overrun_r)
		else $error("overrun not flagged");
	sequence good_stop_s;
		stop_done && keep_char && !overrun_r && rx_on && fif.in_ready;
	endsequence
	framing_error_flag_mark_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		good_stop_s |=> push_data_r[9] == !$past(vote_maj))
		else $error("framing status not stored");
	filter_drop_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		stop_done && address_filter_enable_i && nine_bit_receive_i && !char_word[8] && !push_r
		|=> !push_r)
		else $error("filtered character stored");
	data_shift_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		state_r == asr_pkg::ASR_DATA && at_centre |=> shift_r[8] == $past(vote_maj))
		else $error("data bit not shifted");
	rx_irq_eq_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		receive_irq_o == (receive_pending_flag_o && receive_irq_enable_i && peripheral_irq_enable_i
		&& global_irq_enable_i))
		else $error("receive interrupt gating wrong");
	tx_irq_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		transmit_irq_o == (transmit_empty_flag_o && transmit_irq_enable_i && peripheral_irq_enable_i
		&& global_irq_enable_i))
		else $error("transmit interrupt gating wrong");
	tx_empty_a: assert property (@(posedge clk_sys_i) disable iff (srst_i)
		$rose(tx_on) |=> transmit_empty_flag_o || tx_full_r)
		else $error("empty flag not set");
endmodule // asr_receiver

// *** hw/asr_pkg.sv ***
// Package with constants for the asynchronous serial receiver
package asr_pkg;
	localparam int OVERSAMPLE = 16;
	localparam int HALF_BIT = 8;
	localparam int CNT_W = 4;
	localparam logic [3:0] OS_LAST = 4'hF;
	localparam logic [3:0] OS_HALF = 4'h7;
	localparam logic [3:0] OS_CENTRE = 4'hF;
	localparam logic [3:0] DATA_BITS_8 = 4'h8;
	localparam logic [3:0] DATA_BITS_9 = 4'h9;
	localparam logic [8:0] CHAR_RESET = 9'h000;
	localparam logic [1:0] FIFO_CNT_RESET = 2'h0;
	localparam logic [7:0] TX_DATA_RESET = 8'h00;
	typedef enum logic [2:0] {
		ASR_IDLE = 3'h0,
		ASR_START = 3'h1,
		ASR_DATA = 3'h2,
		ASR_STOP = 3'h3
	} asr_state_e;
endpackage

// *** hw/asr_fifo_if.sv ***
// Interface between the receive engine and the character buffer
`timescale 1ns/1ps
interface asr_fifo_if;
	logic in_valid;
	logic in_ready;
	logic [9:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [9:0] out_data;
	logic flush;
	modport src (output in_valid, output in_data, output flush, input in_ready);
	modport buf_side (input in_valid, input in_data, input flush, output in_ready,
		output out_valid, output out_data, input out_ready);
	modport sink (input out_valid, input out_data, output out_ready);
endinterface

// *** hw/asr_fifo.sv ***
// Two-entry character buffer with framing status and ninth bit
`timescale 1ns/1ps
module asr_fifo (
	input wire logic clk_sys_i,
	input wire logic srst_i,
	asr_fifo_if.buf_side f
);
	logic [9:0] mem_r [0:1];
	logic rd_ptr_r;
	logic wr_ptr_r;
	logic [1:0] cnt_r;
	wire push = f.in_valid && f.in_ready;
	wire pop = f.out_valid && f.out_ready;
	assign f.in_ready = (cnt_r != 2'h2);
	assign f.out_valid = (cnt_r != 2'h0);
	assign f.out_data = mem_r[rd_ptr_r];

	always_ff @(posedge clk_sys_i) begin
		if (srst_i || f.flush) begin
			rd_ptr_r <= 1'b0;
			wr_ptr_r <= 1'b0;
			cnt_r <= asr_pkg::FIFO_CNT_RESET;
		end else begin
			if (push) begin
				mem_r[wr_ptr_r] <= f.in_data;
				wr_ptr_r <= ~wr_ptr_r;
			end
			if (pop)
				rd_ptr_r <= ~rd_ptr_r;
			cnt_r <= 2'(cnt_r + {1'b0, push} - {1'b0, pop});
		end
	end

	always @(posedge clk_sys_i) begin
		fifo_cap_a: assert property (disable iff (srst_i) cnt_r <= 2'h2)
			else $error("buffer count above two");
	end
endmodule // asr_fifo

// *** test/asr_remote_tx.sv ***
// Remote serial transmitter driving the receive line
`timescale 1ns/1ps
module asr_remote_tx #(parameter int BIT_CLKS = 32) (
	input wire logic clk_sys_i,
	input wire logic send_i,
	input wire logic glitch_i,
	input wire logic nine_i,
	input wire logic stop_i,
	input wire logic [8:0] char_i,
	output logic line_o,
	output logic busy_o
);
	initial begin
		line_o = 1'b1;
		busy_o = 1'b0;
	end
	always begin
		@(posedge clk_sys_i);
		if (glitch_i) begin
			busy_o <= 1'b1;
			line_o <= 1'b0;
			repeat (4) @(posedge clk_sys_i);
			line_o <= 1'b1;
			busy_o <= 1'b0;
		end else if (send_i) begin
			busy_o <= 1'b1;
			line_o <= 1'b0;
			repeat (BIT_CLKS) @(posedge clk_sys_i);
			for (int i = 0; i < (nine_i ? 9 : 8); i++) begin
				line_o <= char_i[i];
				repeat (BIT_CLKS) @(posedge clk_sys_i);
			end
			line_o <= stop_i;
			repeat (BIT_CLKS) @(posedge clk_sys_i);
			line_o <= 1'b1;
			busy_o <= 1'b0;
		end
	end
endmodule // asr_remote_tx

// *** test/asr_receiver_tb_top.sv ***
// Testbench for the asynchronous serial receiver
`timescale 1ns/1ps
module asr_receiver_tb_top;
	logic clk = 0, srst = 1, tick = 0, line, busy, snd = 0, gl = 0, stp = 1;
	logic pe = 0, re = 0, n9 = 0, af = 0, rie = 1, pie = 1, global_irq_enable = 1, rd = 0;
	logic te = 0, tie = 0, n9t = 0, t9 = 0, tw = 0, tk = 0;
	logic [7:0] td = 8'h00, rdata;
	logic [8:0] ch = 9'h000, tchar;
	logic r9, fe, ovr, pend, rirq, temp, tirq, tst, ridle;
	int bad_count = 0, n_compared = 0, cyc = 0;
	initial forever #20 clk = ~clk;
	always @(posedge clk) tick <= ~tick;
	asr_remote_tx asr_remote_tx_inst (.clk_sys_i(clk), .send_i(snd), .glitch_i(gl), .nine_i(n9),
		.stop_i(stp), .char_i(ch), .line_o(line), .busy_o(busy));
	asr_receiver asr_receiver_inst (.clk_sys_i(clk), .srst_i(srst), .serial_input_pin_i(line),
		.os_tick_i(tick), .port_enable_i(pe), .receive_enable_i(re), .sync_select_i(1'b0),
		.nine_bit_receive_i(n9), .address_filter_enable_i(af), .receive_irq_enable_i(rie),
		.peripheral_irq_enable_i(pie), .global_irq_enable_i(global_irq_enable), .receive_data_read_i(rd),
		.transmit_enable_i(te), .transmit_irq_enable_i(tie), .nine_bit_transmit_i(n9t),
		.transmit_ninth_bit_i(t9), .transmit_data_register_i(td), .transmit_write_i(tw),
		.transmit_taken_i(tk), .receive_data_register_o(rdata), .receive_ninth_bit_o(r9),
		.framing_error_flag_o(fe), .overrun_flag_o(ovr), .receive_pending_flag_o(pend),
		.receive_irq_o(rirq), .transmit_empty_flag_o(temp), .transmit_irq_o(tirq),
		.transmit_start_o(tst), .transmit_char_o(tchar), .receive_idle_o(ridle));
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic chk(string nm, logic [8:0] e, logic [8:0] g);
		n_compared++;
		if (e !== g) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wt(int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic send(logic [8:0] c, logic s);
		@(posedge clk);
		ch <= c;
		stp <= s;
		snd <= 1'b1;
		@(posedge clk);
		snd <= 1'b0;
		@(posedge clk);
		for (int i = 0; i < 600 && busy === 1'b1; i++) @(posedge clk);
		wt(6);
	endtask
	task automatic pop();
		@(posedge clk);
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		wt(3);
	endtask
	task automatic t_basic();
		send(9'h0A5, 1'b1);
		chk("data", 9'h0A5, {1'b0, rdata});
		chk("pending", 1, pend);
		chk("irq", 1, rirq);
		global_irq_enable <= 1'b0;
		wt(2);
		chk("irq gated", 0, rirq);
		chk("pending kept", 1, pend);
		global_irq_enable <= 1'b1;
		pop();
		chk("pending empty", 0, pend);
	endtask
	task automatic t_frame();
		send(9'h03C, 1'b0);
		send(9'h0C3, 1'b1);
		chk("data1", 9'h03C, {1'b0, rdata});
		chk("ferr1", 1, fe);
		pop();
		chk("data2", 9'h0C3, {1'b0, rdata});
		chk("ferr2", 0, fe);
		pop();
		send(9'h055, 1'b0);
		re <= 1'b0;
		wt(3);
		chk("framing_error_flag rx off", 1, fe);
		re <= 1'b1;
		pe <= 1'b0;
		wt(3);
		chk("framing_error_flag port off", 0, fe);
		chk("flushed", 0, pend);
		chk("idle", 1, ridle);
		pe <= 1'b1;
		wt(2);
		chk("still empty", 0, pend);
	endtask
	task automatic t_overrun();
		send(9'h011, 1'b1);
		send(9'h022, 1'b1);
		send(9'h033, 1'b1);
		chk("overrun", 1, ovr);
		chk("old1", 9'h011, {1'b0, rdata});
		pop();
		chk("old2", 9'h022, {1'b0, rdata});
		pop();
		chk("third lost", 0, pend);
		re <= 1'b0;
		wt(3);
		chk("overrun clr", 0, ovr);
		re <= 1'b1;
		wt(2);
	endtask
	task automatic t_glitch();
		@(posedge clk);
		gl <= 1'b1;
		@(posedge clk);
		gl <= 1'b0;
		wt(40);
		chk("abandon idle", 1, ridle);
		chk("abandon none", 0, pend);
	endtask
	task automatic t_ninebit();
		n9 <= 1'b1;
		af <= 1'b1;
		send(9'h0F0, 1'b1);
		chk("filtered", 0, pend);
		send(9'h1A7, 1'b1);
		chk("addr", 9'h1A7, {r9, rdata});
		pop();
		af <= 1'b0;
		send(9'h05A, 1'b1);
		chk("nine data", 9'h05A, {r9, rdata});
		pop();
		af <= 1'b1;
		n9 <= 1'b0;
		wt(2);
		af <= 1'b0;
	endtask
	task automatic t_transmit();
		tie <= 1'b1;
		te <= 1'b1;
		wt(2);
		chk("tx empty", 1, temp);
		chk("tx irq", 1, tirq);
		n9t <= 1'b1;
		t9 <= 1'b1;
		td <= 8'h6B;
		@(posedge clk);
		tw <= 1'b1;
		@(posedge clk);
		tw <= 1'b0;
		for (int i = 0; i < 10 && tst !== 1'b1; i++) @(posedge clk);
		chk("tx start", 1, tst);
		chk("tx char", 9'h16B, tchar);
		chk("tx full", 0, temp);
		tk <= 1'b1;
		@(posedge clk);
		tk <= 1'b0;
		wt(2);
		chk("tx empty again", 1, temp);
	endtask
	initial begin
		wt(10);
		srst <= 1'b0;
		pe <= 1'b1;
		wt(2);
		re <= 1'b1;
		wt(2);
		t_basic();
		t_frame();
		t_overrun();
		t_glitch();
		t_ninebit();
		t_transmit();
		print_verdict();
	end
endmodule // asr_receiver_tb_top
